// ===== hw/hspc_pkg.sv
package hspc_pkg;
    // ****************************************
    // clocking and timing
    // ****************************************
    localparam int CLK_PERIOD_NS = 4;
    localparam int CLK_HZ = 250_000_000;
    localparam int MS_PERIOD_NS = 1_000_000;
    localparam int MS_CYCLES = MS_PERIOD_NS / CLK_PERIOD_NS;
    // ****************************************
    // backlight pwm
    // ****************************************
    localparam int PWM_STEPS = 128;
    localparam int PWM_HZ_MIN = 250;
    localparam int PWM_HZ_MAX = 10000;
    localparam int PWM_SLOT_NUM = CLK_HZ / PWM_STEPS;
    localparam int PWM_SLOT_MIN = PWM_SLOT_NUM / PWM_HZ_MAX;
    localparam int PWM_SLOT_MAX = PWM_SLOT_NUM / PWM_HZ_MIN;
    localparam logic [15:0] PWM_SLOT_RST = 16'(PWM_SLOT_MAX);
    localparam logic [15:0] PWM_HZ_RST = 16'h00FA;
    localparam logic [7:0] PWM_DUTY_FULL = 8'h80;
    localparam logic [7:0] PWM_DUTY_RST = 8'h80;
    // ****************************************
    // command fifo and engine
    // ****************************************
    localparam int CMD_BYTES = 4096;
    localparam int CMD_AW = 12;
    localparam logic [3:0] CMD_EXEC_CYCLES = 4'h4;
    localparam logic [7:0] CMD_OP_TIMER = 8'h01;
    localparam logic [7:0] PCLK_DIV_RST = 8'h00;
    localparam logic [15:0] LINE_TOTAL_RST = 16'h0000;
    // ****************************************
    // address map (byte addresses on the link)
    // ****************************************
    localparam logic [15:0] ADDR_CMD_END = 16'h1000;
    localparam logic [15:0] ADDR_WIDTH = 16'h2000;
    localparam logic [15:0] ADDR_PWM_HZ_LO = 16'h2004;
    localparam logic [15:0] ADDR_PWM_HZ_HI = 16'h2005;
    localparam logic [15:0] ADDR_PWM_DUTY = 16'h2008;
    localparam logic [15:0] ADDR_CMD_WR_LO = 16'h200C;
    localparam logic [15:0] ADDR_CMD_WR_HI = 16'h200D;
    localparam logic [15:0] ADDR_CMD_RD_LO = 16'h2010;
    localparam logic [15:0] ADDR_CMD_RD_HI = 16'h2011;
    localparam logic [15:0] ADDR_INT_FLAGS = 16'h2014;
    localparam logic [15:0] ADDR_INT_MASK = 16'h2015;
    localparam logic [15:0] ADDR_LINE_TOT_LO = 16'h2018;
    localparam logic [15:0] ADDR_LINE_TOT_HI = 16'h2019;
    localparam logic [15:0] ADDR_PCLK_DIV = 16'h201A;
    localparam logic [15:0] ADDR_LINE_PASS_LO = 16'h201C;
    localparam logic [15:0] ADDR_LINE_PASS_HI = 16'h201D;
    localparam logic [15:0] ADDR_GPIO = 16'h2020;

    typedef enum logic [1:0] {
        HSPC_W_SINGLE = 2'h0,
        HSPC_W_DUAL = 2'h1,
        HSPC_W_QUAD = 2'h2,
        HSPC_W_RSVD = 2'h3
    } hspc_width_t;

    typedef enum logic [1:0] {
        HSPC_E_IDLE = 2'h0,
        HSPC_E_FETCH = 2'h1,
        HSPC_E_EXEC = 2'h3,
        HSPC_E_RETIRE = 2'h2
    } hspc_eng_t;

    // one byte-level event handed from link to core
    typedef struct packed {
        logic fetch;
        logic [15:0] addr;
        logic [7:0] data;
    } hspc_event_t;
endpackage

// ===== hw/hspc_pwm_if.sv
`timescale 1ns/10ps
interface hspc_pwm_if;
    logic [15:0] hz;
    logic [7:0] duty;
    logic bl;
    modport ctrl (output hz, output duty, input bl);
    modport pwm (input hz, input duty, output bl);
endinterface

// ===== hw/hspc_pwm.sv
`timescale 1ns/10ps
module hspc_pwm (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // settings in, output level back
    hspc_pwm_if.pwm pw
);
    import hspc_pkg::*;

    typedef struct packed {
        logic busy;
        logic [4:0] cnt;
        logic [20:0] num;
        logic [21:0] rem;
        logic [20:0] quo;
        logic [13:0] den;
        logic [15:0] hz_done;
        logic [15:0] slot;
        logic [15:0] scnt;
        logic [6:0] phase;
        logic bl;
    } hspc_pwm_st_t;

    hspc_pwm_st_t q_ff;
    hspc_pwm_st_t nxt_q;

    // ****************************************
    // slot length = clock / (hz * 128), by shift-subtract
    // ****************************************
    always_comb begin
        logic [13:0] hz_c;
        logic [21:0] r;
        nxt_q = q_ff;
        hz_c = 14'h0000;
        r = 22'h000000;
        if (pw.hz < 16'(PWM_HZ_MIN)) begin
            hz_c = 14'(PWM_HZ_MIN);
        end else if (pw.hz > 16'(PWM_HZ_MAX)) begin
            hz_c = 14'(PWM_HZ_MAX);
        end else begin
            hz_c = pw.hz[13:0];
        end
        if (!q_ff.busy && pw.hz != q_ff.hz_done) begin
            nxt_q.busy = 1'b1;
            nxt_q.cnt = 5'h00;
            nxt_q.num = 21'(PWM_SLOT_NUM);
            nxt_q.rem = 22'h000000;
            nxt_q.quo = 21'h000000;
            nxt_q.den = hz_c;
            nxt_q.hz_done = pw.hz;
        end else if (q_ff.busy) begin
            r = {q_ff.rem[20:0], q_ff.num[20]};
            nxt_q.num = {q_ff.num[19:0], 1'b0};
            if (r >= {8'h00, q_ff.den}) begin
                nxt_q.rem = r - {8'h00, q_ff.den};
                nxt_q.quo = {q_ff.quo[19:0], 1'b1};
            end else begin
                nxt_q.rem = r;
                nxt_q.quo = {q_ff.quo[19:0], 1'b0};
            end
            nxt_q.cnt = q_ff.cnt + 5'h01;
            if (q_ff.cnt == 5'h14) begin
                nxt_q.busy = 1'b0;
                nxt_q.slot = nxt_q.quo[15:0];
            end
        end
        // ****************************************
        // 128 slots per period, high for duty of them
        // ****************************************
        if (q_ff.scnt >= q_ff.slot - 16'h0001) begin
            nxt_q.scnt = 16'h0000;
            nxt_q.phase = q_ff.phase + 7'h01;
        end else begin
            nxt_q.scnt = q_ff.scnt + 16'h0001;
        end
        nxt_q.bl = (pw.duty >= PWM_DUTY_FULL) || (q_ff.phase < pw.duty[6:0]);
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            q_ff <= '0;
            q_ff.slot <= PWM_SLOT_RST;
        end else begin
            q_ff <= nxt_q;
        end
    end

    assign pw.bl = q_ff.bl;

    localparam int SMIN = PWM_SLOT_MIN;
    localparam int SMAX = PWM_SLOT_MAX;
    property p_slot_range;
        @(posedge mclk) disable iff (rst)
        !q_ff.busy |-> (32'(q_ff.slot) >= SMIN) && (32'(q_ff.slot) <= SMAX);
    endproperty
    a_slot_range: assert property (p_slot_range) else $error("pwm slot out of range");
endmodule // hspc_pwm

// ===== hw/hspc_host_port.sv
`timescale 1ns/10ps
module hspc_host_port #(
    parameter int MS_CYC = hspc_pkg::MS_CYCLES
) (
    // core clock and reset
    input wire logic mclk,
    input wire logic rst,
    // serial link
    input wire logic sck,
    input wire logic cs_n,
    input wire logic [3:0] io_in,
    output logic [3:0] io_out,
    output logic [3:0] io_oe_n,
    // to host and panel
    output logic int_n,
    output logic backlight_en
);
    import hspc_pkg::*;

    typedef struct packed {
        logic [3:0] bits;
        logic [2:0] idx;
        logic wr;
        logic [15:0] addr;
        logic [7:0] sh;
        logic [7:0] osh;
        logic [3:0] dout;
        logic [3:0] oe_n;
    } hspc_frm_t;

    typedef struct packed {
        hspc_width_t width;
        logic req;
        logic par;
        hspc_event_t slot0;
        hspc_event_t slot1;
    } hspc_lnk_t;

    typedef struct packed {
        logic s1, s2, s3, par;
        logic [1:0] w1, w2;
        logic [7:0] rd0, rd1;
        logic [15:0] hz;
        logic [7:0] duty;
        logic [11:0] cwr, crd;
        logic iflag, imask;
        logic [15:0] ltot;
        logic [7:0] pdiv, pcnt;
        logic [15:0] hcnt, lpass;
        logic [1:0] gpio;
        hspc_eng_t st;
        logic [1:0] fb;
        logic [31:0] word;
        logic [3:0] ecnt;
        logic ton;
        logic [15:0] tms;
        logic [31:0] pre;
        logic int_n, bl;
    } hspc_core_t;

    hspc_frm_t frm_ff, nxt_frm;
    hspc_lnk_t lnk_ff, nxt_lnk;
    hspc_core_t cor_ff, nxt_cor;
    logic [7:0] cmd_mem [CMD_BYTES];
    hspc_pwm_if pwm_if ();

    function automatic logic [3:0] lead_bits(input logic [7:0] v, input hspc_width_t w);
        case (w)
            HSPC_W_QUAD: lead_bits = v[7:4];
            HSPC_W_DUAL: lead_bits = {2'h0, v[7:6]};
            default: lead_bits = {2'h0, v[7], 1'b0};
        endcase
    endfunction

    // ****************************************
    // link side, on the host's serial clock
    // ****************************************
    always_comb begin
        logic [3:0] nb;
        logic [7:0] shv, ldv;
        logic [3:0] bsum;
        logic post;
        hspc_event_t ev;
        nb = 4'h1;
        shv = frm_ff.sh;
        nxt_frm = frm_ff;
        nxt_lnk = lnk_ff;
        post = 1'b0;
        ev = '0;
        ldv = frm_ff.addr[0] ? cor_ff.rd1 : cor_ff.rd0;
        case (lnk_ff.width)
            HSPC_W_QUAD: begin
                nb = 4'h4;
                shv = {frm_ff.sh[3:0], io_in};
            end
            HSPC_W_DUAL: begin
                nb = 4'h2;
                shv = {frm_ff.sh[5:0], io_in[1:0]};
            end
            default: begin
                nb = 4'h1;
                shv = {frm_ff.sh[6:0], io_in[0]};
            end
        endcase
        bsum = frm_ff.bits + nb;
        nxt_frm.sh = shv;
        nxt_frm.bits = (bsum == 4'h8) ? 4'h0 : bsum;
        if (!frm_ff.wr && frm_ff.idx == 3'h4) begin
            nxt_frm.dout = lead_bits(frm_ff.osh, lnk_ff.width);
            nxt_frm.osh = frm_ff.osh << nb;
        end
        if (bsum == 4'h8) begin
            case (frm_ff.idx)
                3'h0: begin
                    nxt_frm.wr = shv[7];
                    nxt_frm.addr = {1'b0, shv[6:0], 8'h00};
                    nxt_frm.idx = 3'h1;
                end
                3'h1: begin
                    nxt_frm.addr[7:0] = shv;
                    nxt_frm.idx = frm_ff.wr ? 3'h4 : 3'h2;
                    post = !frm_ff.wr;
                    // data bit 0 marks the byte the host really asked for
                    ev = '{1'b1, {frm_ff.addr[15:8], shv}, 8'h01};
                end
                3'h2: begin
                    nxt_frm.idx = 3'h3;
                    post = 1'b1;
                    ev = '{1'b1, frm_ff.addr + 16'h0001, 8'h00};
                end
                default: begin
                    nxt_frm.idx = 3'h4;
                    nxt_frm.addr = frm_ff.addr + 16'h0001;
                    if (frm_ff.wr) begin
                        if (frm_ff.addr == ADDR_WIDTH) begin
                            if (shv[1:0] != HSPC_W_RSVD) begin
                                nxt_lnk.width = hspc_width_t'(shv[1:0]);
                            end
                        end else begin
                            post = 1'b1;
                            ev = '{1'b0, frm_ff.addr, shv};
                        end
                    end else begin
                        // two bytes prefetched ahead hides the crossing delay
                        nxt_frm.dout = lead_bits(ldv, lnk_ff.width);
                        nxt_frm.osh = ldv << nb;
                        nxt_frm.oe_n = (lnk_ff.width == HSPC_W_QUAD) ? 4'h0 :
                            (lnk_ff.width == HSPC_W_DUAL) ? 4'hC : 4'hD;
                        post = 1'b1;
                        ev = '{1'b1, frm_ff.addr + 16'h0002, 8'h00};
                    end
                end
            endcase
        end
        if (post) begin
            nxt_lnk.req = ~lnk_ff.req;
            nxt_lnk.par = ~lnk_ff.par;
            if (lnk_ff.par) begin
                nxt_lnk.slot1 = ev;
            end else begin
                nxt_lnk.slot0 = ev;
            end
        end
    end

    // chip select ends the frame; no sck edge after it is counted on
    always_ff @(posedge sck or posedge cs_n) begin
        if (cs_n) begin
            frm_ff <= '0;
            frm_ff.oe_n <= 4'hF;
        end else begin
            frm_ff <= nxt_frm;
        end
    end

    // serial clock may be stopped during reset, hence asynchronous here
    always_ff @(posedge sck or posedge rst) begin
        if (rst) begin
            lnk_ff <= '0;
        end else if (!cs_n) begin
            lnk_ff <= nxt_lnk;
        end
    end

    // ****************************************
    // core side
    // ****************************************
    function automatic logic [7:0] rd_byte(input hspc_core_t c, input logic [15:0] a);
        logic [7:0] cm;
        cm = cmd_mem[a[CMD_AW-1:0]];
        if (a < ADDR_CMD_END) rd_byte = cm;
        else case (a)
            ADDR_WIDTH: rd_byte = {6'h00, c.w2};
            ADDR_PWM_HZ_LO: rd_byte = c.hz[7:0];
            ADDR_PWM_HZ_HI: rd_byte = c.hz[15:8];
            ADDR_PWM_DUTY: rd_byte = c.duty;
            ADDR_CMD_WR_LO: rd_byte = c.cwr[7:0];
            ADDR_CMD_WR_HI: rd_byte = {4'h0, c.cwr[11:8]};
            ADDR_CMD_RD_LO: rd_byte = c.crd[7:0];
            ADDR_CMD_RD_HI: rd_byte = {4'h0, c.crd[11:8]};
            ADDR_INT_FLAGS: rd_byte = {7'h00, c.iflag};
            ADDR_INT_MASK: rd_byte = {7'h00, c.imask};
            ADDR_LINE_TOT_LO: rd_byte = c.ltot[7:0];
            ADDR_LINE_TOT_HI: rd_byte = c.ltot[15:8];
            ADDR_PCLK_DIV: rd_byte = c.pdiv;
            ADDR_LINE_PASS_LO: rd_byte = c.lpass[7:0];
            ADDR_LINE_PASS_HI: rd_byte = c.lpass[15:8];
            ADDR_GPIO: rd_byte = {6'h00, c.gpio};
            default: rd_byte = 8'h00;
        endcase
    endfunction

    always_comb begin
        hspc_event_t ev;
        logic take, fire;
        nxt_cor = cor_ff;
        nxt_cor.s1 = lnk_ff.req;
        nxt_cor.s2 = cor_ff.s1;
        nxt_cor.s3 = cor_ff.s2;
        nxt_cor.w1 = lnk_ff.width;
        nxt_cor.w2 = cor_ff.w1;
        take = cor_ff.s2 ^ cor_ff.s3;
        ev = cor_ff.par ? lnk_ff.slot1 : lnk_ff.slot0;
        fire = 1'b0;
        if (take) begin
            nxt_cor.par = ~cor_ff.par;
            if (ev.fetch) begin
                if (ev.addr[0]) nxt_cor.rd1 = rd_byte(cor_ff, ev.addr);
                else nxt_cor.rd0 = rd_byte(cor_ff, ev.addr);
                // prefetches run ahead of the host, so only the first byte clears
                if (ev.addr == ADDR_INT_FLAGS && ev.data[0]) nxt_cor.iflag = 1'b0;
            end else begin
                case (ev.addr)
                    ADDR_PWM_HZ_LO: nxt_cor.hz[7:0] = ev.data;
                    ADDR_PWM_HZ_HI: nxt_cor.hz[15:8] = ev.data;
                    ADDR_PWM_DUTY: nxt_cor.duty = (ev.data > PWM_DUTY_FULL) ? PWM_DUTY_FULL : ev.data;
                    ADDR_CMD_WR_LO: nxt_cor.cwr[7:0] = ev.data;
                    ADDR_CMD_WR_HI: nxt_cor.cwr[11:8] = ev.data[3:0];
                    ADDR_INT_MASK: nxt_cor.imask = ev.data[0];
                    ADDR_LINE_TOT_LO: nxt_cor.ltot[7:0] = ev.data;
                    ADDR_LINE_TOT_HI: nxt_cor.ltot[15:8] = ev.data;
                    ADDR_PCLK_DIV: nxt_cor.pdiv = ev.data;
                    ADDR_GPIO: nxt_cor.gpio = ev.data[1:0];
                    default: ;
                endcase
            end
        end
        // command engine: circular, pointers wrap at 4 Kbyte
        case (cor_ff.st)
            HSPC_E_IDLE: begin
                if (cor_ff.crd != cor_ff.cwr) begin
                    nxt_cor.st = HSPC_E_FETCH;
                    nxt_cor.fb = 2'h0;
                end
            end
            HSPC_E_FETCH: begin
                nxt_cor.word = {cmd_mem[cor_ff.crd + 12'(cor_ff.fb)], cor_ff.word[31:8]};
                nxt_cor.fb = cor_ff.fb + 2'h1;
                if (cor_ff.fb == 2'h3) begin
                    nxt_cor.st = HSPC_E_EXEC;
                    nxt_cor.ecnt = CMD_EXEC_CYCLES;
                end
            end
            HSPC_E_EXEC: begin
                nxt_cor.ecnt = cor_ff.ecnt - 4'h1;
                if (cor_ff.ecnt == 4'h1) begin
                    nxt_cor.st = HSPC_E_RETIRE;
                    if (cor_ff.word[31:24] == CMD_OP_TIMER) begin
                        nxt_cor.ton = 1'b1;
                        nxt_cor.tms = cor_ff.word[15:0];
                        nxt_cor.pre = 32'h00000000;
                    end
                end
            end
            HSPC_E_RETIRE: begin
                nxt_cor.crd = cor_ff.crd + 12'h004;
                nxt_cor.st = HSPC_E_IDLE;
            end
            default: nxt_cor.st = HSPC_E_IDLE;
        endcase
        if (cor_ff.ton) begin
            nxt_cor.pre = cor_ff.pre + 32'h00000001;
            if (cor_ff.pre == 32'(MS_CYC - 1)) begin
                nxt_cor.pre = 32'h00000000;
                nxt_cor.tms = cor_ff.tms - 16'h0001;
                if (cor_ff.tms <= 16'h0001) begin
                    nxt_cor.ton = 1'b0;
                    fire = 1'b1;
                end
            end
        end
        if (fire) nxt_cor.iflag = 1'b1;
        nxt_cor.int_n = ~(cor_ff.iflag & cor_ff.imask);
        // one display list pass per line of pixel clocks
        if (cor_ff.pdiv != 8'h00 && cor_ff.ltot != 16'h0000) begin
            nxt_cor.pcnt = cor_ff.pcnt + 8'h01;
            if (cor_ff.pcnt >= cor_ff.pdiv - 8'h01) begin
                nxt_cor.pcnt = 8'h00;
                nxt_cor.hcnt = cor_ff.hcnt + 16'h0001;
                if (cor_ff.hcnt >= cor_ff.ltot - 16'h0001) begin
                    nxt_cor.hcnt = 16'h0000;
                    nxt_cor.lpass = cor_ff.lpass + 16'h0001;
                end
            end
        end
        nxt_cor.bl = pwm_if.bl;
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            cor_ff <= '0;
            cor_ff.hz <= PWM_HZ_RST;
            cor_ff.duty <= PWM_DUTY_RST;
            cor_ff.ltot <= LINE_TOTAL_RST;
            cor_ff.pdiv <= PCLK_DIV_RST;
            cor_ff.int_n <= 1'b1;
        end else begin
            cor_ff <= nxt_cor;
        end
    end

    hspc_event_t mem_ev;
    assign mem_ev = cor_ff.par ? lnk_ff.slot1 : lnk_ff.slot0;
    always_ff @(posedge mclk) begin
        if ((cor_ff.s2 ^ cor_ff.s3) && !mem_ev.fetch && mem_ev.addr < ADDR_CMD_END) begin
            cmd_mem[mem_ev.addr[CMD_AW-1:0]] <= mem_ev.data;
        end
    end

    assign pwm_if.hz = cor_ff.hz;
    assign pwm_if.duty = cor_ff.duty;
    hspc_pwm u_pwm (.mclk(mclk), .rst(rst), .pw(pwm_if.pwm));

    // lines 2,3 belong to gpio unless the link runs quad
    assign io_out = {(lnk_ff.width == HSPC_W_QUAD) ? frm_ff.dout[3:2] : cor_ff.gpio,
        frm_ff.dout[1:0]};
    assign io_oe_n = {(lnk_ff.width == HSPC_W_QUAD) ? frm_ff.oe_n[3:2] : 2'h0,
        frm_ff.oe_n[1:0]};
    assign int_n = cor_ff.int_n;
    assign backlight_en = cor_ff.bl;

    // ****************************************
    // checks
    // ****************************************
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);

    property p_width_legal;
        cor_ff.w2 != HSPC_W_RSVD;
    endproperty
    a_width_legal: assert property (p_width_legal) else $error("reserved width active");
    property p_int_pin;
        (cor_ff.iflag && cor_ff.imask) |=> !int_n;
    endproperty
    a_int_pin: assert property (p_int_pin) else $error("interrupt not signalled");
    property p_int_idle;
        !(cor_ff.iflag && cor_ff.imask) |=> int_n;
    endproperty
    a_int_idle: assert property (p_int_idle) else $error("spurious interrupt");
    property p_rd_retire;
        $changed(cor_ff.crd) |-> $past(cor_ff.st) == HSPC_E_RETIRE;
    endproperty
    a_rd_retire: assert property (p_rd_retire) else $error("read pointer moved early");
    property p_rd_step;
        cor_ff.st == HSPC_E_RETIRE |=> cor_ff.crd == $past(cor_ff.crd) + 12'h004;
    endproperty
    a_rd_step: assert property (p_rd_step) else $error("read pointer step wrong");
    property p_exec_len;
        $rose(cor_ff.st == HSPC_E_EXEC) |-> (cor_ff.st == HSPC_E_EXEC)[*4] ##1
            cor_ff.st == HSPC_E_RETIRE;
    endproperty
    a_exec_len: assert property (p_exec_len) else $error("exec length wrong");
    property p_duty_full;
        (cor_ff.duty == PWM_DUTY_FULL)[*3] |-> backlight_en;
    endproperty
    a_duty_full: assert property (p_duty_full) else $error("full duty not on");
    property p_duty_zero;
        (cor_ff.duty == 8'h00)[*3] |-> !backlight_en;
    endproperty
    a_duty_zero: assert property (p_duty_zero) else $error("zero duty not off");
    property p_timer_fire;
        cor_ff.ton && cor_ff.pre == 32'(MS_CYC - 1) && cor_ff.tms <= 16'h0001
            |=> cor_ff.iflag ##1 !int_n || !cor_ff.imask;
    endproperty
    a_timer_fire: assert property (p_timer_fire) else $error("timer did not fire");
    c_retire: cover property (cor_ff.st == HSPC_E_RETIRE);
    c_timer: cover property (cor_ff.ton ##1 !cor_ff.ton);
    c_quad: cover property (cor_ff.w2 == HSPC_W_QUAD);
    c_line: cover property ($changed(cor_ff.lpass));
endmodule // hspc_host_port

// ===== dv/hspc_host_model.sv
`timescale 1ns/10ps
// ****************************************
// host link master, mode 0; sck idles low
// ****************************************
module hspc_host_model (
    // link
    output logic sck,
    output logic cs_n,
    output logic [3:0] io_in,
    // device drive
    input wire logic [3:0] io_out,
    input wire logic [3:0] io_oe_n
);
    logic [3:0] drv = 4'h0;
    logic [3:0] oe_seen;
    // undriven lines swing every bit so stale data never passes
    assign io_in = (io_oe_n & drv) | (~io_oe_n & io_out);
    initial begin
        sck = 1'b0;
        // late rise at time zero so the frame flops see a real edge
        cs_n <= 1'b1;
    end
    task automatic xbyte(input logic [1:0] w, input logic [7:0] tx, output logic [7:0] rx);
        int n;
        n = (w == 2'h2) ? 4 : (w == 2'h1) ? 2 : 1;
        rx = 8'h00;
        for (int k = 0; k < 8; k += n) begin
            drv = (n == 4) ? tx[7:4] : (n == 2) ? {~drv[3:2], tx[7:6]} : {~drv[3:1], tx[7]};
            #3;
            oe_seen = io_oe_n;
            rx = (n == 4) ? {rx[3:0], io_out} :
                (n == 2) ? {rx[5:0], io_out[1:0]} : {rx[6:0], io_out[1]};
            sck = 1'b1;
            #3;
            sck = 1'b0;
            tx = tx << n;
        end
    endtask
    task automatic xfer(input logic [1:0] w, input logic wr, input logic [15:0] a,
                        input logic [31:0] wd, input int nb, output logic [31:0] rd);
        logic [7:0] r;
        cs_n = 1'b0;
        #3;
        xbyte(w, {wr, a[14:8]}, r);
        xbyte(w, a[7:0], r);
        if (!wr) begin
            xbyte(w, 8'hA5, r);
            xbyte(w, 8'h5A, r);
        end
        rd = 32'h0;
        for (int i = 0; i < nb; i++) begin
            xbyte(w, wd[8*i+:8], r);
            rd[8*i+:8] = r;
        end
        #3;
        cs_n = 1'b1;
        #12;
    endtask
endmodule // hspc_host_model

// ===== dv/hspc_host_port_test.sv
`timescale 1ns/10ps
module hspc_host_port_test;
    import hspc_pkg::*;
    logic mclk = 1'b0;
    // starts low so the rise at time zero clears the link flops
    logic rst = 1'b0;
    logic sck, cs_n, int_n, backlight_en;
    logic [3:0] io_in, io_out, io_oe_n;
    logic [31:0] rd;
    int err_count = 0;
    int checked = 0;
    always #2 mclk = ~mclk;
    hspc_host_port #(.MS_CYC(50)) u_dut (.mclk(mclk), .rst(rst), .sck(sck), .cs_n(cs_n),
        .io_in(io_in), .io_out(io_out), .io_oe_n(io_oe_n), .int_n(int_n),
        .backlight_en(backlight_en));
    hspc_host_model u_host (.sck(sck), .cs_n(cs_n), .io_in(io_in), .io_out(io_out),
        .io_oe_n(io_oe_n));
    // ****************************************
    // helpers
    // ****************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            $display("unexpected at %0t: got %0h want %0h", $time, got, exp);
            err_count++;
        end
    endtask
    task automatic wr(input logic [1:0] w, input logic [15:0] a, input logic [31:0] d, input int nb);
        u_host.xfer(w, 1'b1, a, d, nb, rd);
    endtask
    task automatic rdr(input logic [1:0] w, input logic [15:0] a, input int nb);
        u_host.xfer(w, 1'b0, a, 32'h0, nb, rd);
    endtask
    task automatic wait_n(input int n);
        repeat (n) @(posedge mclk);
    endtask
    task automatic end_of_test;
        $display("errors %0d checks %0d", err_count, checked);
        if (err_count == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_reset;
        chk(int_n, 1'b1);
        wait_n(40);
        chk(backlight_en, 1'b1);
        rdr(2'h0, ADDR_WIDTH, 1);
        chk(rd, 32'h0);
    endtask
    task automatic t_width;
        wr(2'h0, ADDR_WIDTH, 32'h3, 1);
        rdr(2'h0, ADDR_WIDTH, 1);
        chk(rd, 32'h0);
        wr(2'h0, ADDR_WIDTH, 32'h1, 1);
        rdr(2'h1, ADDR_WIDTH, 1);
        chk(rd, 32'h1);
        wr(2'h1, ADDR_WIDTH, 32'h2, 1);
        rdr(2'h2, ADDR_WIDTH, 1);
        chk(rd, 32'h2);
        chk(u_host.oe_seen, 4'h0);
        wr(2'h2, ADDR_WIDTH, 32'h0, 1);
        rdr(2'h0, ADDR_WIDTH, 1);
        chk(rd, 32'h0);
    endtask
    task automatic t_cmd;
        int n;
        wr(2'h0, 16'h0000, 32'h0100_0002, 4);
        wr(2'h0, ADDR_INT_MASK, 32'h1, 1);
        wr(2'h0, ADDR_CMD_WR_LO, 32'h4, 2);
        n = 0;
        while (int_n !== 1'b0 && n < 300) begin
            @(posedge mclk);
            n++;
        end
        chk(n >= 95 && n <= 125, 1'b1);
        rdr(2'h0, ADDR_CMD_RD_LO, 2);
        chk(rd, 32'h4);
        rdr(2'h0, ADDR_INT_FLAGS, 1);
        chk(rd, 32'h1);
        wait_n(4);
        chk(int_n, 1'b1);
    endtask
    task automatic t_pwm;
        int hi;
        int up;
        logic last;
        wr(2'h0, ADDR_PWM_HZ_LO, 32'h03E8, 2);
        wr(2'h0, ADDR_PWM_DUTY, 32'h0, 1);
        wait_n(30);
        hi = 0;
        repeat (26000) begin
            @(posedge mclk);
            hi += (backlight_en === 1'b1);
        end
        chk(32'(hi), 32'h0);
        wr(2'h0, ADDR_PWM_DUTY, 32'h40, 1);
        wait_n(30);
        up = 0;
        last = backlight_en;
        repeat (50100) begin
            @(posedge mclk);
            up += (backlight_en !== last);
            last = backlight_en;
        end
        // half a 1000 Hz period outlasts this window: one edge at most
        chk(up <= 1, 1'b1);
        wr(2'h0, ADDR_PWM_DUTY, 32'h80, 1);
        wait_n(30);
        hi = 0;
        repeat (4000) begin
            @(posedge mclk);
            hi += (backlight_en === 1'b1);
        end
        chk(32'(hi), 32'h0FA0);
    endtask
    task automatic t_line;
        logic [31:0] first;
        wr(2'h0, ADDR_LINE_TOT_LO, 32'h0198, 2);
        wr(2'h0, ADDR_PCLK_DIV, 32'h6, 1);
        rdr(2'h0, ADDR_LINE_PASS_LO, 2);
        first = rd;
        wait_n(4896);
        rdr(2'h0, ADDR_LINE_PASS_LO, 2);
        chk((rd - first >= 2) && (rd - first <= 3), 1'b1);
    endtask
    initial begin
        rst <= 1'b1;
        wait_n(6);
        rst <= 1'b0;
        wait_n(1);
        t_reset();
        t_width();
        t_cmd();
        t_line();
        t_pwm();
        end_of_test();
    end
    initial begin
        #400_000;
        err_count++;
        end_of_test();
    end
endmodule // hspc_host_port_test
